// >>> rcc_top.v
// Real-time counter control registers, flag protection and divided clock output.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_map.vh"
// Functional notes
// - While the clock supply enable is 0, control register writes are ignored and reads give reset values.
// - Output enables should change only while counting is stopped, since changing them while running may glitch.
// - A single-bit write to the second control register may clear both flags it holds.
// - Writing 1 to a flag position leaves the flag unchanged; software writes whole bytes with ones there.
// - A stopped divided output toggles for at most two subsystem clocks, then rests low.
module rcc_top
#(
  parameter DIV_W = 16
)
(
  input wire clk,
  input wire rst_n,
  input wire subsystem_osc_clock,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire fix_event,
  input wire alarm_event,
  output reg [7:0] rdata,
  output reg khz_out,
  output reg one_hz_out,
  output reg divided_clock_out_pin,
  output reg irq
);
  // ****************************************************************
  // Subsystem clock edge detection and event synchronisers
  // ****************************************************************
  wire sub_tick;
  reg fix_s1_r;
  reg fix_s2_r;
  reg alm_s1_r;
  reg alm_s2_r;
  rcc_edge u_edge
  (
    .clk(clk),
    .rst_n(rst_n),
    .din(subsystem_osc_clock),
    .rise_r(sub_tick)
  );
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fix_s1_r <= 1'b0;
      fix_s2_r <= 1'b0;
      alm_s1_r <= 1'b0;
      alm_s2_r <= 1'b0;
    end
    else
    begin
      fix_s1_r <= fix_event;
      fix_s2_r <= fix_s1_r;
      alm_s1_r <= alarm_event;
      alm_s2_r <= alm_s1_r;
    end
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] per_r;
  reg [7:0] ctl0_r;
  reg [7:0] ctl1_r;
  reg [7:0] ctl2_r;
  reg [1:0] stat_r;
  reg [1:0] mask_r;
  reg fix_d_r;
  reg alm_d_r;
  wire cnt_en = per_r[`RCC_PER_CNT_EN];
  wire fix_set = fix_s2_r & ~fix_d_r;
  wire alm_set = alm_s2_r & ~alm_d_r;
  wire [1:0] ev;
  assign ev[`RCC_EV_FIX] = fix_set;
  assign ev[`RCC_EV_ALARM] = alm_set;
  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Control writes are qualified by the clock supply enable, the others are not.
  wire wr_per = wr & (addr == `RCC_ADDR_PER);
  wire wr_ctl0 = wr & cnt_en & (addr == `RCC_ADDR_CTL0);
  wire wr_ctl1 = wr & cnt_en & (addr == `RCC_ADDR_CTL1);
  wire wr_ctl2 = wr & cnt_en & (addr == `RCC_ADDR_CTL2);
  wire wr_stat = wr & (addr == `RCC_ADDR_IRQ_STAT);
  wire wr_mask = wr & (addr == `RCC_ADDR_IRQ_MASK);
  // ****************************************************************
  // Event edge detection
  // ****************************************************************
  // Events arrive as levels from the counting logic; only their rising edges set flags.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fix_d_r <= 1'b0;
      alm_d_r <= 1'b0;
    end
    else
    begin
      fix_d_r <= fix_s2_r;
      alm_d_r <= alm_s2_r;
    end
  end
  // ****************************************************************
  // Peripheral enable register
  // ****************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      per_r <= `RCC_RST_BYTE;
    else if (wr_per)
    begin
      per_r <= wdata;
      // The reserved bit never stores a one, whatever software writes.
      per_r[`RCC_PER_RSVD] <= 1'b0;
    end
  end
  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Without the clock supply enable the control registers are held at their reset value.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl0_r <= `RCC_RST_BYTE;
      ctl2_r <= `RCC_RST_BYTE;
    end
    else if (!cnt_en)
    begin
      ctl0_r <= `RCC_RST_BYTE;
      ctl2_r <= `RCC_RST_BYTE;
    end
    else
    begin
      if (wr_ctl0)
        ctl0_r <= wdata;
      if (wr_ctl2)
        ctl2_r <= wdata;
    end
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl1_r <= `RCC_RST_BYTE;
    else if (!cnt_en)
      ctl1_r <= `RCC_RST_BYTE;
    else if (wr_ctl1)
    begin
      ctl1_r <= wdata;
      // A written 1 keeps a flag, a written 0 clears it; a new event wins.
      ctl1_r[`RCC_CTL1_FIX_FLAG] <= fix_set | (ctl1_r[`RCC_CTL1_FIX_FLAG] & wdata[`RCC_CTL1_FIX_FLAG]);
      ctl1_r[`RCC_CTL1_ALARM_FLAG] <= alm_set | (ctl1_r[`RCC_CTL1_ALARM_FLAG] & wdata[`RCC_CTL1_ALARM_FLAG]);
    end
    else
    begin
      if (fix_set)
        ctl1_r[`RCC_CTL1_FIX_FLAG] <= 1'b1;
      if (alm_set)
        ctl1_r[`RCC_CTL1_ALARM_FLAG] <= 1'b1;
    end
  end
  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
    end
    else
    begin
      // A set that meets a write-one-to-clear in the same cycle wins.
      if (wr_stat)
        stat_r <= ev | (stat_r & ~wdata[1:0]);
      else
        stat_r <= stat_r | ev;
      if (wr_mask)
        mask_r <= wdata[1:0];
    end
  end
  // ****************************************************************
  // Read port and interrupt
  // ****************************************************************
  // Control reads are gated by the enable too, which covers the cycle in which they are still being cleared.
  reg [7:0] rd_mux;
  wire [1:0] pend = stat_r & mask_r;
  always @*
  begin
    case (addr)
      `RCC_ADDR_PER: rd_mux = per_r;
      `RCC_ADDR_CTL0: rd_mux = cnt_en ? ctl0_r : `RCC_RST_BYTE;
      `RCC_ADDR_CTL1: rd_mux = cnt_en ? ctl1_r : `RCC_RST_BYTE;
      `RCC_ADDR_CTL2: rd_mux = cnt_en ? ctl2_r : `RCC_RST_BYTE;
      `RCC_ADDR_IRQ_STAT: rd_mux = {6'h00, stat_r};
      `RCC_ADDR_IRQ_MASK: rd_mux = {6'h00, mask_r};
      default: rd_mux = 8'h00;
    endcase
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else
      rdata <= rd ? rd_mux : 8'h00;
  end
  // The interrupt is a level, one cycle behind the status bits.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |pend;
  end
  // ****************************************************************
  // Clock dividers and outputs
  // ****************************************************************
  wire run = ctl0_r[`RCC_CTL0_RUN];
  wire [2:0] div_sel = ctl2_r[`RCC_CTL2_DIV_SEL_HI:`RCC_CTL2_DIV_SEL_LO];
  wire div_en = ctl2_r[`RCC_CTL2_DIV_EN];
  reg [DIV_W-1:0] div_cnt_r;
  reg [1:0] tail_r;
  reg div_act_r;
  reg sub_pulse_r;
  // The tap select picks counter bit sel plus the base, so larger codes give slower outputs.
  wire div_tap = div_cnt_r[{1'b0, div_sel} + `RCC_DIV_TAP_BASE];
  // Counting restarts from zero when run goes low, so the first period may be short.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_r <= {DIV_W{1'b0}};
    else if (!run)
      div_cnt_r <= {DIV_W{1'b0}};
    else if (sub_tick)
      div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
  end
  // A one-cycle pulse on every synchronised subsystem rising edge feeds the kHz output.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sub_pulse_r <= 1'b0;
    else
      sub_pulse_r <= sub_tick;
  end
  // ****************************************************************
  // Clock outputs
  // ****************************************************************
  // Enables take effect immediately, which is why changing them while running may glitch.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      khz_out <= 1'b0;
    else
      khz_out <= ctl0_r[`RCC_CTL0_KHZ_OE] & sub_pulse_r;
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      one_hz_out <= 1'b0;
    else
      one_hz_out <= ctl0_r[`RCC_CTL0_HZ_OE] & run & div_cnt_r[DIV_W-1];
  end
  // ****************************************************************
  // Divided clock output pin
  // ****************************************************************
  // After the enable falls the pin runs out a short tail on subsystem edges, then rests low.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divided_clock_out_pin <= 1'b0;
      tail_r <= 2'h0;
      div_act_r <= 1'b0;
    end
    else if (div_en && run)
    begin
      div_act_r <= 1'b1;
      tail_r <= `RCC_STOP_TAIL;
      divided_clock_out_pin <= div_tap;
    end
    else if (div_act_r)
    begin
      if (sub_tick)
      begin
        if (tail_r == 2'h0)
        begin
          div_act_r <= 1'b0;
          divided_clock_out_pin <= 1'b0;
        end
        else
        begin
          tail_r <= tail_r - 2'h1;
          divided_clock_out_pin <= ~divided_clock_out_pin;
        end
      end
    end
    else
      divided_clock_out_pin <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> rcc_map.vh
// Register offsets, field positions and timing constants of the real-time counter control block.
`ifndef RCC_MAP_VH
`define RCC_MAP_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define RCC_ADDR_PER 4'h0
`define RCC_ADDR_CTL0 4'h1
`define RCC_ADDR_CTL1 4'h2
`define RCC_ADDR_CTL2 4'h3
`define RCC_ADDR_IRQ_STAT 4'h4
`define RCC_ADDR_IRQ_MASK 4'h5
// ****************************************************************
// Field positions
// ****************************************************************
`define RCC_PER_CNT_EN 7
`define RCC_PER_RSVD 1
`define RCC_CTL0_RUN 7
`define RCC_CTL0_KHZ_OE 6
`define RCC_CTL0_HZ_OE 5
`define RCC_CTL1_ALARM_FLAG 4
`define RCC_CTL1_FIX_FLAG 3
`define RCC_CTL2_INT_EN 7
`define RCC_CTL2_DIV_EN 6
`define RCC_CTL2_DIV_SEL_HI 5
`define RCC_CTL2_DIV_SEL_LO 3
`define RCC_CTL2_SEL_HI 2
`define RCC_CTL2_SEL_LO 0
// ****************************************************************
// Reset values and event bits
// ****************************************************************
`define RCC_RST_BYTE 8'h00
`define RCC_EV_FIX 0
`define RCC_EV_ALARM 1
// ****************************************************************
// Timing
// ****************************************************************
`define RCC_STOP_TAIL 2'h2
`define RCC_DIV_TAP_BASE 4'h5
`endif

// >>> rcc_edge.v
// Rising-edge detector for the subsystem clock after a two-stage synchroniser.
`timescale 1ns/100ps
`default_nettype none
module rcc_edge
(
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg rise_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      rise_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise_r <= s2_r & ~s3_r;
    end
  end
endmodule
`default_nettype wire

// >>> rcc_top_checker.sv
// Assertion checker for the real-time counter control block.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_map.vh"
module rcc_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic subsystem_osc_clock,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic khz_out,
  input wire logic divided_clock_out_pin,
  input wire logic irq
);
  logic en_r, khz_r, div_r, sub_r;
  logic [2:0] stop_r;
  // Shadows of the enables; stop_r counts subsystem edges since the divided output was switched off.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_r <= 1'b0;
      khz_r <= 1'b0;
      div_r <= 1'b0;
      sub_r <= 1'b0;
      stop_r <= 3'h0;
    end
    else
    begin
      sub_r <= subsystem_osc_clock;
      if (wr && addr == `RCC_ADDR_PER)
        en_r <= wdata[`RCC_PER_CNT_EN];
      if (!en_r)
        khz_r <= 1'b0;
      else if (wr && addr == `RCC_ADDR_CTL0)
        khz_r <= wdata[`RCC_CTL0_KHZ_OE];
      if (!en_r)
        div_r <= 1'b0;
      else if (wr && addr == `RCC_ADDR_CTL2)
        div_r <= wdata[`RCC_CTL2_DIV_EN];
      if (div_r)
        stop_r <= 3'h0;
      else if (subsystem_osc_clock && !sub_r && stop_r != 3'h4)
        stop_r <= stop_r + 3'h1;
    end
  end
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  unmapped_zero_a: assert property (rd && addr > `RCC_ADDR_IRQ_MASK |=> rdata == 8'h00)
    else $error("unmapped read gave data");
  idle_zero_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its slot");
  gate_rd_a: assert property (
    rd && !en_r && addr != `RCC_ADDR_PER && addr <= `RCC_ADDR_CTL2 |=> rdata == 8'h00)
    else $error("gated control read nonzero");
  rsvd_bit_a: assert property (rd && addr == `RCC_ADDR_PER |=> !rdata[1])
    else $error("reserved enable bit read as one");
  en_rd_a: assert property (
    wr && addr == `RCC_ADDR_PER ##1 !wr ##1 rd && addr == `RCC_ADDR_PER |=> rdata[7] == $past(wdata[7], 3))
    else $error("clock supply enable did not read back");
  mask_irq_a: assert property (wr && addr == `RCC_ADDR_IRQ_MASK && wdata == 8'h00 ##1 !wr |=> !irq)
    else $error("irq high with all sources masked");
  khz_off_a: assert property (!khz_r && $past(khz_r) == 1'b0 |-> !khz_out)
    else $error("khz output active while disabled");
  div_stop_a: assert property (stop_r == 3'h4 |-> !divided_clock_out_pin)
    else $error("divided output not low after stop");
endmodule
bind rcc_top rcc_chk u_chk (.clk, .rst_n, .subsystem_osc_clock, .addr, .wdata, .wr, .rd, .rdata, .khz_out,
  .divided_clock_out_pin, .irq);
`default_nettype wire

// >>> rcc_top_tb_top.sv
// Self-checking testbench for the real-time counter control block.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_map.vh"
module rcc_top_tb_top;
  localparam logic [3:0] pe = `RCC_ADDR_PER, c0 = `RCC_ADDR_CTL0, c1 = `RCC_ADDR_CTL1, c2 = `RCC_ADDR_CTL2;
  localparam logic [3:0] st = `RCC_ADDR_IRQ_STAT, mk = `RCC_ADDR_IRQ_MASK;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sub = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fev = 1'b0;
  logic aev = 1'b0;
  logic [7:0] rdata;
  logic khz, divo, irq, prev, hz;
  int errors = 0;
  int n_checks = 0;
  int tog, kh;
  always #5 clk = ~clk;
  // The subsystem clock runs fast so that divider taps turn over within a short run.
  always #100 sub = ~sub;
  rcc_top dut (.clk(clk), .rst_n(rst_n), .subsystem_osc_clock(sub), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .fix_event(fev), .alarm_event(aev), .rdata(rdata), .khz_out(khz), .one_hz_out(hz), .divided_clock_out_pin(divo),
    .irq(irq));
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(what, exp, rdata);
    @(posedge clk);
  endtask
  task automatic cirq(input logic e);
    #1;
    cmp("irq", {7'h0, e}, {7'h0, irq});
    @(posedge clk);
  endtask
  task automatic watch(input int n);
    tog = 0;
    kh = 0;
    #1;
    prev = divo;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      tog = tog + int'(divo ^ prev);
      kh = kh + int'(khz);
      prev = divo;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(pe, 8'h00, "per");
    for (int i = 1; i < 4; i++)
    begin
      wreg(4'(i), 8'hE7);
      rreg(4'(i), 8'h00, "gated");
    end
    wreg(pe, 8'h82);
    rreg(pe, 8'h80, "per");
    wreg(c2, 8'h07);
    rreg(c2, 8'h07, "ctl2");
    {fev, aev} <= 2'h3;
    repeat (4) @(posedge clk);
    {fev, aev} <= 2'h0;
    repeat (4) @(posedge clk);
    rreg(c1, 8'h18, "flags");
    wreg(c1, 8'h18);
    rreg(c1, 8'h18, "flags kept");
    wreg(c1, 8'h10);
    rreg(c1, 8'h10, "fix clear");
    wreg(c1, 8'h08);
    rreg(c1, 8'h00, "alarm clear");
    rreg(st, 8'h03, "status");
    cirq(1'b0);
    wreg(mk, 8'h01);
    cirq(1'b1);
    wreg(st, 8'h01);
    cirq(1'b0);
    wreg(mk, 8'h02);
    cirq(1'b1);
    wreg(mk, 8'h00);
    cirq(1'b0);
    wreg(st, 8'h02);
    rreg(st, 8'h00, "status");
    rreg(4'hF, 8'h00, "unmapped");
    wreg(c2, 8'h40);
    wreg(c0, 8'h60);
    wreg(c0, 8'hE0);
    watch(3000);
    cmp("div toggles", 8'h01, {7'h0, tog > 2});
    cmp("khz pulses", 8'h01, {7'h0, kh > 0});
    cmp("1hz first half", 8'h00, {7'h0, hz});
    wreg(c2, 8'h00);
    repeat (100) @(posedge clk);
    watch(800);
    cmp("div stopped", 8'h00, {7'h0, tog != 0 || divo !== 1'b0});
    wreg(c0, 8'h60);
    wreg(c0, 8'h00);
    #1;
    cmp("khz off", 8'h00, {7'h0, khz});
    wreg(c2, 8'h05);
    wreg(pe, 8'h00);
    rreg(c2, 8'h00, "gated after disable");
    wreg(c2, 8'h05);
    rreg(c2, 8'h00, "write while gated");
    tally_and_finish();
  end
endmodule
`default_nettype wire
